/* File: hw/csc_top.sv */
// Status outputs, battery switch sequencing and input limit control.
// Assumes async analog status levels and a one-cycle register port.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module csc_top import csc_pkg::*; #(
    parameter int unsigned INT_CYC = CSC_INT_CYC,
    parameter int unsigned BLINK_CYC = CSC_BLINK_CYC,
    parameter int unsigned LONG_CYC = CSC_LONG_CYC,
    parameter int unsigned DGL_CYC = CSC_DGL_CYC,
    parameter int unsigned SDLY_CYC = CSC_SDLY_CYC,
    parameter int unsigned ROFF_CYC = CSC_ROFF_CYC,
    parameter int unsigned PW_CYC = CSC_PW_CYC,
    parameter int unsigned PN_UP = CSC_PN_UP,
    parameter int unsigned PN_DN = CSC_PN_DN
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [15:0] bus_rdata,
    // Asynchronous status inputs
    input wire csc_pins_t pins,
    // Status outputs
    output logic input_good_n,
    output logic chg_pin_o,
    output logic chg_pin_oe_n,
    output logic int_n,
    // Power path controls
    output logic battery_system_switch,
    output logic [5:0] eff_limit,
    output logic limit_pin_active
);
    // Switch and pulse sequencer states
    typedef enum logic [1:0] {SW_ON, SW_WAIT, SW_SHIP, SW_RST} csc_sw_t;
    typedef enum logic [1:0] {P_IDLE, P_LOW, P_HIGH} csc_pump_t;

    // Reset release synchroniser
    logic [1:0] rsync_r;
    wire rst_n = rsync_r[1];
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) rsync_r <= 2'h0;
        else rsync_r <= {rsync_r[0], 1'b1};
    end

    // Two-stage input sync, plus a delayed copy for edges
    csc_pins_t s1_r, s2_r, d_r;
    // Idle levels after reset; a zero button would look pressed
    localparam csc_pins_t PINS_IDLE = '{btn_n: 1'b1, default: '0};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= PINS_IDLE;
            s2_r <= PINS_IDLE;
            d_r <= PINS_IDLE;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            d_r <= s2_r;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Register port decode
    wire wr_ctrl = bus_wr && (bus_addr == CSC_A_CTRL);
    wire wr_lim = bus_wr && (bus_addr == CSC_A_LIMIT);
    wire rd_fault = bus_rd && (bus_addr == CSC_A_FAULT);
    // Soft reset is a write strobe, not a stored bit
    wire soft_rst = wr_ctrl && bus_wdata[CSC_B_REGRST];

    // Register state
    logic [15:0] ctrl_r, ctrl_nxt; // Control bits
    logic [5:0] lim_r;             // Programmed input limit
    logic [7:0] flt_r;             // Fault register image
    logic flt_latched_r;           // Fault interrupt already sent
    csc_sw_t sw_r, sw_nxt;         // Switch sequencer
    csc_pump_t pst_r, pst_nxt;     // Pulse sequencer
    logic [31:0] swcnt_r;          // Switch timer
    logic [31:0] pcnt_r;           // Pulse width timer
    logic [31:0] pnum_r;           // Pulses done
    logic [31:0] btn_cnt_r;        // Button low time
    logic [31:0] icnt_r;           // Interrupt pulse timer
    logic [31:0] bcnt_r;           // Blink timer
    logic blink_r;                 // Blink phase

    // Input good combination, now and one cycle back
    wire good_w = s2_r.uvlo_ok && s2_r.above_bat && s2_r.below_ovp
        && s2_r.not_poor && s2_r.det_done;
    wire good_d = d_r.uvlo_ok && d_r.above_bat && d_r.below_ovp
        && d_r.not_poor && d_r.det_done;

    // Interrupt events, each a one-cycle pulse
    wire ev_src = s2_r.src_id && !d_r.src_id;
    wire ev_good = good_w && !good_d;
    wire ev_rm = !s2_r.uvlo_ok && d_r.uvlo_ok;
    wire ev_done = (s2_r.chg == CSC_CHG_DONE) && (d_r.chg != CSC_CHG_DONE);
    // New faults only count while nothing is latched
    wire flt_new = !flt_latched_r && (|s2_r.fault);
    wire ev_any = ev_src || ev_good || ev_rm || ev_done || flt_new;

    // Button timing: one-cycle hits as thresholds are crossed
    wire btn_low = !s2_r.btn_n;
    wire dgl_hit = btn_low && (btn_cnt_r == DGL_CYC - 1);
    wire long_hit = btn_low && (btn_cnt_r == LONG_CYC - 1);
    wire ev_plug = s2_r.uvlo_ok && !d_r.uvlo_ok;

    // Pulse sequencer decode
    wire busy = ctrl_r[CSC_B_UP] || ctrl_r[CSC_B_DN];
    wire [31:0] pn = ctrl_r[CSC_B_UP] ? PN_UP : PN_DN;
    wire pw_end = (pcnt_r == PW_CYC - 1);
    wire p_last = (pst_r == P_HIGH) && pw_end && (pnum_r == pn - 1);
    wire p_abort = (pst_r != P_IDLE) && !ctrl_r[CSC_B_PEN];
    wire pump_end = p_abort || p_last;
    // Start only with protocol on, idle, and exactly one request
    wire up_w = bus_wdata[CSC_B_UP];
    wire dn_w = bus_wdata[CSC_B_DN];
    wire start_ok = ctrl_r[CSC_B_PEN] && bus_wdata[CSC_B_PEN]
        && !busy && (up_w ^ dn_w);
    // Hardware wake from ship mode drops the off request
    wire hw_wake = (sw_r == SW_SHIP) && (ev_plug || dgl_hit);

    // Control register next value
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = bus_wdata & CSC_CTRL_WMASK;
            // Request bits only move on a legal start
            ctrl_nxt[CSC_B_UP] = start_ok ? up_w : ctrl_r[CSC_B_UP];
            ctrl_nxt[CSC_B_DN] = start_ok ? dn_w : ctrl_r[CSC_B_DN];
        end
        if (pump_end) begin
            ctrl_nxt[CSC_B_UP] = 1'b0;
            ctrl_nxt[CSC_B_DN] = 1'b0;
        end
        if (hw_wake) begin
            ctrl_nxt[CSC_B_OFF] = 1'b0;
        end
        if (soft_rst) begin
            ctrl_nxt = CSC_CTRL_RST;
        end
    end

    // Control and limit registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CSC_CTRL_RST;
            lim_r <= CSC_LIMIT_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (soft_rst) lim_r <= CSC_LIMIT_RST;
            else if (wr_lim) lim_r <= bus_wdata[5:0];
        end
    end

    a_reg_reset: assert property (soft_rst |=> ctrl_r == CSC_CTRL_RST
        && lim_r == CSC_LIMIT_RST) else $error("soft reset failed");

    // Fault latch; a read reloads from live faults so that the
    // second read shows them, and a same-cycle event is not lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flt_r <= 8'h00;
            flt_latched_r <= 1'b0;
        end else if (soft_rst) begin
            flt_r <= 8'h00;
            flt_latched_r <= 1'b0;
        end else if (rd_fault) begin
            flt_r <= s2_r.fault;
            flt_latched_r <= |s2_r.fault;
        end else if (flt_new) begin
            flt_r <= s2_r.fault;
            flt_latched_r <= 1'b1;
        end
    end

    a_fault_hold: assert property (flt_latched_r && !rd_fault
        && !soft_rst |=> $stable(flt_r)) else $error("fault moved");
    a_fault_live: assert property (rd_fault
        |=> flt_r == $past(s2_r.fault)) else $error("no live reload");
    a_fault_quiet: assert property (flt_latched_r && !rd_fault
        && !ev_src && !ev_good && !ev_rm && !ev_done
        |=> icnt_r != INT_CYC) else $error("fault int repeated");

    // Interrupt pulse timer; retriggers on any event
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) icnt_r <= 32'h0;
        else if (ev_any) icnt_r <= INT_CYC;
        else if (icnt_r != 32'h0) icnt_r <= icnt_r - 32'h1;
    end

    sequence s_int_start;
        ev_any ##1 (icnt_r == INT_CYC && !int_n);
    endsequence
    a_int_pulse: assert property (ev_any |-> s_int_start)
        else $error("interrupt pulse missing");
    a_int_cause: assert property ($fell(int_n) |-> $past(ev_any))
        else $error("interrupt without event");
    a_done_int: assert property (ev_done |=> !int_n
        && $past(s2_r.chg) == CSC_CHG_DONE) else $error("done no int");

    // Blink divider, equal halves
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_r <= 32'h0;
            blink_r <= 1'b0;
        end else if (bcnt_r == BLINK_CYC - 1) begin
            bcnt_r <= 32'h0;
            blink_r <= !blink_r;
        end else begin
            bcnt_r <= bcnt_r + 32'h1;
        end
    end

    // Charge pin selection, release means enable high
    wire charging = (s2_r.chg == CSC_CHG_PRE) || (s2_r.chg == CSC_CHG_FAST);
    wire suspended = s2_r.suspend || s2_r.boost_susp;
    wire pin_oe_n_w = ctrl_r[CSC_B_PINOFF] ? 1'b1
        : suspended ? blink_r
        : charging ? 1'b0 : 1'b1;

    // Input limit selection; the pin only counts when enabled
    wire pin_lower = ctrl_r[CSC_B_LIMIT_PIN] && (s2_r.pin_lim < lim_r);
    wire [5:0] sel_lim = pin_lower ? s2_r.pin_lim : lim_r;
    wire [5:0] eff_w = (pst_r == P_LOW) ? CSC_LIM_100MA : sel_lim;

    // Registered status outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            input_good_n <= 1'b1;
            chg_pin_o <= 1'b0;
            chg_pin_oe_n <= 1'b1;
            int_n <= 1'b1;
            eff_limit <= CSC_LIMIT_RST;
            limit_pin_active <= 1'b0;
        end else begin
            input_good_n <= !good_w;
            chg_pin_o <= 1'b0;
            chg_pin_oe_n <= pin_oe_n_w;
            int_n <= !(ev_any || (icnt_r > 32'h1));
            eff_limit <= eff_w;
            limit_pin_active <= ctrl_r[CSC_B_LIMIT_PIN];
        end
    end

    a_good_pin: assert property (##1 input_good_n == !$past(good_w))
        else $error("input good wrong");
    a_pin_off: assert property (ctrl_r[CSC_B_PINOFF] |=> chg_pin_oe_n)
        else $error("charge pin driven");
    a_pin_chg: assert property (charging && !suspended
        && !ctrl_r[CSC_B_PINOFF] |=> !chg_pin_oe_n)
        else $error("charge pin not low");
    a_lim_min: assert property (pst_r != P_LOW |=> eff_limit
        <= $past(lim_r)) else $error("limit above register");
    a_lim_nopin: assert property (!ctrl_r[CSC_B_LIMIT_PIN] && pst_r != P_LOW
        |=> eff_limit == $past(lim_r)) else $error("pin limit used");

    // Button low-time counter, saturating at the long press
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) btn_cnt_r <= 32'h0;
        else if (!btn_low) btn_cnt_r <= 32'h0;
        else if (btn_cnt_r != LONG_CYC) btn_cnt_r <= btn_cnt_r + 32'h1;
    end

    // Switch sequencer next state
    always_comb begin
        sw_nxt = sw_r;
        case (sw_r)
            SW_ON: begin
                if (ctrl_r[CSC_B_OFF]) begin
                    sw_nxt = ctrl_r[CSC_B_DLY] ? SW_WAIT : SW_SHIP;
                end else if (long_hit && ctrl_r[CSC_B_BRST]
                        && !s2_r.uvlo_ok) begin
                    sw_nxt = SW_RST;
                end
            end
            SW_WAIT: begin
                // Request withdrawn during the delay keeps power on
                if (!ctrl_r[CSC_B_OFF]) sw_nxt = SW_ON;
                else if (swcnt_r == SDLY_CYC - 1) sw_nxt = SW_SHIP;
            end
            SW_SHIP: begin
                if (!ctrl_r[CSC_B_OFF] || ev_plug || dgl_hit) begin
                    sw_nxt = SW_ON;
                end
            end
            SW_RST: begin
                if (swcnt_r == ROFF_CYC - 1) sw_nxt = SW_ON;
            end
            default: sw_nxt = SW_ON;
        endcase
    end

    // Switch state, timer and output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_r <= SW_ON;
            swcnt_r <= 32'h0;
            battery_system_switch <= 1'b1;
        end else begin
            sw_r <= sw_nxt;
            swcnt_r <= (sw_nxt != sw_r) ? 32'h0 : swcnt_r + 32'h1;
            battery_system_switch <= (sw_nxt == SW_ON) || (sw_nxt == SW_WAIT);
        end
    end

    a_ship_now: assert property (sw_r == SW_ON && ctrl_r[CSC_B_OFF]
        && !ctrl_r[CSC_B_DLY] |=> !battery_system_switch)
        else $error("switch not opened");
    a_ship_wake: assert property (sw_r == SW_SHIP && !ctrl_r[CSC_B_OFF]
        |=> battery_system_switch) else $error("switch not closed");
    a_long_off: assert property (sw_r == SW_ON && !ctrl_r[CSC_B_OFF]
        && long_hit && ctrl_r[CSC_B_BRST] && !s2_r.uvlo_ok
        |=> !battery_system_switch && sw_r == SW_RST)
        else $error("long press ignored");
    a_brst_inh: assert property (sw_r == SW_ON && !ctrl_r[CSC_B_BRST]
        |=> sw_r != SW_RST) else $error("reset not inhibited");

    // Pulse sequencer next state
    always_comb begin
        pst_nxt = pst_r;
        case (pst_r)
            P_IDLE: begin
                if (busy && ctrl_r[CSC_B_PEN]) pst_nxt = P_LOW;
            end
            P_LOW: begin
                if (p_abort) pst_nxt = P_IDLE;
                else if (pw_end) pst_nxt = P_HIGH;
            end
            P_HIGH: begin
                if (pump_end) pst_nxt = P_IDLE;
                else if (pw_end) pst_nxt = P_LOW;
            end
            default: pst_nxt = P_IDLE;
        endcase
    end

    // Pulse sequencer state and counters
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pst_r <= P_IDLE;
            pcnt_r <= 32'h0;
            pnum_r <= 32'h0;
        end else begin
            pst_r <= pst_nxt;
            pcnt_r <= (pst_nxt != pst_r) ? 32'h0 : pcnt_r + 32'h1;
            if (pst_nxt == P_IDLE) pnum_r <= 32'h0;
            else if (pst_r == P_HIGH && pst_nxt == P_LOW) begin
                pnum_r <= pnum_r + 32'h1;
            end
        end
    end

    sequence s_pump_last;
        ctrl_r[CSC_B_PEN] && p_last;
    endsequence
    a_pump_done: assert property (s_pump_last |=> !busy
        && pst_r == P_IDLE) else $error("sequence not closed");
    a_pump_abort: assert property (p_abort |=> (pst_r == P_IDLE
        && !busy) ##1 eff_limit == $past(sel_lim))
        else $error("abort failed");
    a_pump_low: assert property (pst_r == P_LOW |=>
        eff_limit == CSC_LIM_100MA) else $error("low limit missing");
    a_pump_ign: assert property (wr_ctrl && !ctrl_r[CSC_B_PEN] && !busy
        |=> !busy) else $error("request taken while off");
    a_pump_busy: assert property (pst_r != P_IDLE && !pump_end
        && !soft_rst |=> busy) else $error("busy dropped");

    // Read data mux, registered for the following cycle
    wire [15:0] stat_w = {5'h00, eff_limit, busy, !input_good_n,
        battery_system_switch, s2_r.chg};
    wire [15:0] rd_val = (bus_addr == CSC_A_CTRL) ? ctrl_r
        : (bus_addr == CSC_A_LIMIT) ? {10'h000, lim_r}
        : (bus_addr == CSC_A_FAULT) ? {8'h00, flt_r}
        : (bus_addr == CSC_A_STAT) ? stat_w : 16'h0000;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) bus_rdata <= 16'h0000;
        else bus_rdata <= bus_rd ? rd_val : 16'h0000;
    end
endmodule // csc_top
`default_nettype wire

/* File: pkg/csc_pkg.sv */
// Constants, register map and pin bundle of the charger status block.
// Assumes a 100 MHz core clock and a simple strobe register port.
package csc_pkg;
    // Core clock rate
    localparam int unsigned CSC_CLK_MHZ = 100;
    // Interrupt pulse width
    localparam int unsigned CSC_INT_US = 256;
    localparam int unsigned CSC_INT_CYC = CSC_INT_US * CSC_CLK_MHZ;
    // Charge pin blink rate, half period in cycles
    localparam int unsigned CSC_BLINK_HZ = 1;
    localparam int unsigned CSC_BLINK_CYC =
        (CSC_CLK_MHZ * 1000000) / (2 * CSC_BLINK_HZ);
    // Push-button long press
    localparam int unsigned CSC_LONG_S = 15;
    localparam int unsigned CSC_LONG_CYC =
        CSC_LONG_S * CSC_CLK_MHZ * 1000000;
    // Ship entry delay, exit deglitch, reset off time (plain defaults)
    localparam int unsigned CSC_SDLY_MS = 10;
    localparam int unsigned CSC_SDLY_CYC = CSC_SDLY_MS * CSC_CLK_MHZ * 1000;
    localparam int unsigned CSC_DGL_MS = 1;
    localparam int unsigned CSC_DGL_CYC = CSC_DGL_MS * CSC_CLK_MHZ * 1000;
    localparam int unsigned CSC_ROFF_MS = 250;
    localparam int unsigned CSC_ROFF_CYC = CSC_ROFF_MS * CSC_CLK_MHZ * 1000;
    // Adapter current pulse width and counts (plain defaults)
    localparam int unsigned CSC_PW_MS = 100;
    localparam int unsigned CSC_PW_CYC = CSC_PW_MS * CSC_CLK_MHZ * 1000;
    localparam int unsigned CSC_PN_UP = 3;
    localparam int unsigned CSC_PN_DN = 2;
    // Register offsets
    localparam logic [7:0] CSC_A_CTRL = 8'h00;
    localparam logic [7:0] CSC_A_LIMIT = 8'h04;
    localparam logic [7:0] CSC_A_FAULT = 8'h08;
    localparam logic [7:0] CSC_A_STAT = 8'h0C;
    // Control register bits
    localparam int CSC_B_REGRST = 0;
    localparam int CSC_B_PINOFF = 1;
    localparam int CSC_B_OFF = 2;
    localparam int CSC_B_DLY = 3;
    localparam int CSC_B_BRST = 4;
    localparam int CSC_B_PEN = 5;
    localparam int CSC_B_UP = 6;
    localparam int CSC_B_DN = 7;
    localparam int CSC_B_LIMIT_PIN = 8;
    localparam logic [15:0] CSC_CTRL_RST = 16'h0110;
    localparam logic [15:0] CSC_CTRL_WMASK = 16'h01FE;
    // Input limit codes, 50 mA steps from 100 mA
    localparam logic [5:0] CSC_LIMIT_RST = 6'h08;
    localparam logic [5:0] CSC_LIM_100MA = 6'h00;
    // Charge state codes
    localparam logic [1:0] CSC_CHG_IDLE = 2'h0;
    localparam logic [1:0] CSC_CHG_PRE = 2'h1;
    localparam logic [1:0] CSC_CHG_FAST = 2'h2;
    localparam logic [1:0] CSC_CHG_DONE = 2'h3;
    // Asynchronous status inputs from the analog side and pins
    typedef struct packed {
        logic uvlo_ok;
        logic above_bat;
        logic below_ovp;
        logic not_poor;
        logic det_done;
        logic src_id;
        logic suspend;
        logic boost_susp;
        logic [1:0] chg;
        logic [5:0] pin_lim;
        logic [7:0] fault;
        logic btn_n;
    } csc_pins_t;
endpackage

/* File: testbench/csc_adapter_model.sv */
// Adapter side: counts input current pulses seen on the limit.
// Assumes code 0 is the 100 mA step and the set limit is above it.
`timescale 1ns/1ps
`default_nettype none
module csc_adapter_model (
    // Clock
    input wire logic clk,
    // Limit that the adapter feels, count clear
    input wire logic [5:0] eff_limit,
    input wire logic clr,
    // Pulses heard so far
    output logic [7:0] pulses
);
    logic [5:0] prev_r; // Limit one cycle ago
    // Each entry into the 100 mA step is one pulse
    always_ff @(posedge clk) begin
        prev_r <= eff_limit;
        if (clr) begin
            pulses <= 8'h00;
        end else if (eff_limit == 6'h00 && prev_r != 6'h00) begin
            pulses <= pulses + 8'h01;
        end
    end
endmodule // csc_adapter_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the charger status block.
// Assumes shortened timing parameters and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top import csc_pkg::*; ;
    localparam int PW = 5, SDLY = 10, DGL = 4, LONG = 40, ROFF = 10;
    logic clk, resetn, bus_wr, bus_rd, clr, input_good_n, chg_pin_o;
    logic chg_pin_oe_n, int_n, sw, limit_pin_active;
    logic [7:0] bus_addr, pulses;
    logic [15:0] bus_wdata, bus_rdata, d;
    logic [5:0] eff_limit, lim, pl;
    logic [4:0] v;
    csc_pins_t pins; // Analog status levels and pins
    int n_errors = 0, comparisons = 0, i, k, lows;
    integer seed = 32'hcf568e6e; // Fixed seed keeps runs repeatable
    csc_top #(.INT_CYC(8), .BLINK_CYC(4), .LONG_CYC(LONG), .DGL_CYC(DGL),
        .SDLY_CYC(SDLY), .ROFF_CYC(ROFF), .PW_CYC(PW), .PN_UP(3),
        .PN_DN(2)) csc_top_inst (.clk(clk), .resetn(resetn),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .pins(pins),
        .input_good_n(input_good_n), .chg_pin_o(chg_pin_o),
        .chg_pin_oe_n(chg_pin_oe_n), .int_n(int_n),
        .battery_system_switch(sw), .eff_limit(eff_limit),
        .limit_pin_active(limit_pin_active));
    csc_adapter_model csc_adapter_model_inst (.clk(clk),
        .eff_limit(eff_limit), .clr(clr), .pulses(pulses));
    // Expected limit is the lower of pin and register
    function automatic logic [5:0] min6(input logic [5:0] a, b);
        return (a < b) ? a : b;
    endfunction
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] x);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= x;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Single-bit compare, widened on purpose
    task automatic chk1(input logic got, input logic exp);
        chk({15'h0, got}, {15'h0, exp});
    endtask
    // Read data only stand in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
        chk(d, exp);
    endtask
    // Bounded wait for interrupt (sel 1) or switch (sel 0) to reach val
    task automatic wt(input bit sel, input logic val, input int n);
        for (k = 0; k < n && (sel ? int_n : sw) !== val; k++) w(1);
        chk1(sel ? int_n : sw, val);
    endtask
    // Counts low cycles of charge pin (sel 1) or switch (sel 0)
    task automatic cnt(input bit sel, input int n);
        lows = 0;
        for (k = 0; k < n; k++) begin
            lows += ((sel ? chg_pin_oe_n : sw) === 1'b0);
            w(1);
        end
    endtask
    task automatic set_good(input logic [4:0] x);
        pins.uvlo_ok <= x[0];
        pins.above_bat <= x[1];
        pins.below_ovp <= x[2];
        pins.not_poor <= x[3];
        pins.det_done <= x[4];
    endtask
    task automatic end_sim;
        $display("n_errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog, far beyond the few hundred cycles of the run
    initial begin
        #200000;
        n_errors++;
        end_sim;
    end
    initial begin
        resetn = 1'b0;
        {bus_wr, bus_rd, bus_addr, bus_wdata, clr} = '0;
        pins = '0;
        pins.btn_n = 1'b1;
        pins.pin_lim = 6'h3F;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        w(4);
        // Defaults, and an unmapped place reads zero
        rchk(CSC_A_CTRL, CSC_CTRL_RST);
        rchk(CSC_A_LIMIT, 16'h0008);
        rchk(8'h10, 16'h0000);
        chk1(limit_pin_active, 1'b1);
        // Random mixes of the five input conditions
        for (i = 0; i < 12; i++) begin
            v = 5'($random(seed));
            set_good(i == 0 ? 5'h1F : v);
            w(5);
            chk1(input_good_n, (i == 0) ? 1'b0 : ~&v);
        end
        set_good(5'h00);
        wt(1, 1'b1, 40);
        // Source identified raises one pulse
        pins.src_id <= 1'b1;
        wt(1, 1'b0, 5);
        wt(1, 1'b1, 20);
        // Fault latch, suppression and double read
        pins.fault <= 8'h01;
        wt(1, 1'b0, 5);
        wt(1, 1'b1, 20);
        pins.fault <= 8'h02;
        cnt(1, 1);
        w(6);
        chk1(int_n, 1'b1);
        rchk(CSC_A_FAULT, 16'h0001);
        rchk(CSC_A_FAULT, 16'h0002);
        pins.fault <= 8'h00;
        w(4);
        rchk(CSC_A_FAULT, 16'h0002);
        pins.fault <= 8'h04;
        wt(1, 1'b0, 5);
        pins.fault <= 8'h00;
        w(4);
        rchk(CSC_A_FAULT, 16'h0004);
        // Charge pin: driven, switched off, blinking, done
        pins.chg <= CSC_CHG_FAST;
        w(5);
        chk(16'({chg_pin_oe_n, chg_pin_o}), 16'h0000);
        wr(CSC_A_CTRL, 16'h0112);
        w(4);
        chk1(chg_pin_oe_n, 1'b1);
        wr(CSC_A_CTRL, 16'h0110);
        pins.suspend <= 1'b1;
        w(5);
        cnt(1, 16);
        chk(16'(lows), 16'h0008);
        // Temperature boost suspend blinks the same way
        pins.suspend <= 1'b0;
        pins.boost_susp <= 1'b1;
        w(5);
        cnt(1, 16);
        chk(16'(lows), 16'h0008);
        pins.boost_susp <= 1'b0;
        wt(1, 1'b1, 30);
        pins.chg <= CSC_CHG_DONE;
        wt(1, 1'b0, 5);
        chk1(chg_pin_oe_n, 1'b1);
        // Status: default limit, idle, input not good, switch closed
        rchk(CSC_A_STAT, {5'h00, CSC_LIMIT_RST, 3'h1, CSC_CHG_DONE});
        pins.chg <= CSC_CHG_IDLE;
        // Random register and pin limits
        for (i = 0; i < 8; i++) begin
            lim = 6'($random(seed));
            pl = 6'($random(seed));
            pins.pin_lim <= pl;
            wr(CSC_A_LIMIT, {10'h000, lim});
            w(5);
            chk(16'(eff_limit), 16'(min6(lim, pl)));
        end
        wr(CSC_A_CTRL, 16'h0010);
        w(4);
        chk(16'({limit_pin_active, eff_limit}), 16'(lim));
        wr(CSC_A_LIMIT, 16'h0008);
        pins.pin_lim <= 6'h3F;
        // Requests while the protocol is off are dropped
        wr(CSC_A_CTRL, 16'h0150);
        rchk(CSC_A_CTRL, 16'h0110);
        chk(16'(eff_limit), 16'h0008);
        // Up then down sequences, then one aborted early
        for (i = 0; i < 3; i++) begin
            clr <= 1'b1;
            wr(CSC_A_CTRL, 16'h0130);
            clr <= 1'b0;
            wr(CSC_A_CTRL, (i == 1) ? 16'h01B0 : 16'h0170);
            if (i < 2) begin
                rchk(CSC_A_CTRL, i ? 16'h01B0 : 16'h0170);
                w(2 * PW * (i ? 2 : 3) + 10);
                chk(16'(pulses), i ? 16'h0002 : 16'h0003);
                rchk(CSC_A_CTRL, 16'h0130);
                chk(16'(eff_limit), 16'h0008);
            end else begin
                w(3);
                chk(16'(eff_limit), 16'h0000);
                wr(CSC_A_CTRL, 16'h0110);
                w(4 * PW);
                chk({pulses, 2'b00, eff_limit}, 16'h0108);
                rchk(CSC_A_CTRL, 16'h0110);
            end
        end
        // Ship mode entry and the four ways out
        wr(CSC_A_CTRL, 16'h0114);
        wt(0, 1'b0, 4);
        wr(CSC_A_CTRL, 16'h0110);
        wt(0, 1'b1, 4);
        wr(CSC_A_CTRL, 16'h011C);
        w(SDLY - 4);
        chk1(sw, 1'b1);
        wt(0, 1'b0, 10);
        pins.btn_n <= 1'b0;
        wt(0, 1'b1, DGL + 6);
        pins.btn_n <= 1'b1;
        wr(CSC_A_CTRL, 16'h0114);
        wt(0, 1'b0, 4);
        pins.uvlo_ok <= 1'b1;
        wt(0, 1'b1, 6);
        pins.uvlo_ok <= 1'b0;
        wr(CSC_A_CTRL, 16'h0114);
        wt(0, 1'b0, 4);
        wr(CSC_A_CTRL, 16'h0001);
        wt(0, 1'b1, 4);
        rchk(CSC_A_CTRL, CSC_CTRL_RST);
        // Long press: inhibited, then a full off-on cycle
        wr(CSC_A_CTRL, 16'h0100);
        pins.btn_n <= 1'b0;
        cnt(0, LONG + ROFF + 10);
        chk(16'(lows), 16'h0000);
        pins.btn_n <= 1'b1;
        wr(CSC_A_CTRL, 16'h0110);
        pins.btn_n <= 1'b0;
        wt(0, 1'b0, LONG + 8);
        pins.btn_n <= 1'b1;
        cnt(0, ROFF + 6);
        // Switch open for exactly the reset interval, then closed
        chk(16'({sw, lows[7:0]}), 16'({1'b1, 8'(ROFF)}));
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
